// ---- hdl/uart_pkg.sv ----
// holds the constants and carrier types of one serial channel
// assumes a 20 MHz ref_clk and a byte-wide host register port
package uart_pkg;
	localparam logic [2:0] OFS_DATA   = 3'h0;
	localparam logic [2:0] OFS_IEN    = 3'h1;
	localparam logic [2:0] OFS_IDENT  = 3'h2;
	localparam logic [2:0] OFS_LFMT   = 3'h3;
	localparam logic [2:0] OFS_MCTL   = 3'h4;
	localparam logic [2:0] OFS_LSTATE = 3'h5;
	localparam logic [2:0] OFS_MSTATE = 3'h6;
	localparam logic [2:0] OFS_SCR    = 3'h7;
	localparam logic [7:0] OFS_FCR_SHADOW1 = 8'h20;
	localparam logic [7:0] OFS_FCR_SHADOW2 = 8'h21;
	localparam logic [7:0] OFS_EV_STATUS   = 8'h30;
	localparam logic [7:0] OFS_EV_CLEAR    = 8'h31;
	localparam logic [7:0] OFS_EV_ENABLE   = 8'h32;
	localparam logic [7:0] OFS_CONFIG      = 8'h33;
	localparam int LF_BANK   = 7;
	localparam int LF_BREAK  = 6;
	localparam int LF_STICK  = 5;
	localparam int LF_EVEN   = 4;
	localparam int LF_PARITY = 3;
	localparam int LF_STOP   = 2;
	localparam int FC_ENABLE = 0;
	localparam int FC_RXCLR  = 1;
	localparam int FC_TXCLR  = 2;
	localparam int CFG_LEGACY = 0;
	localparam int CFG_HSPEED = 1;
	localparam int CFG_CHAN2  = 2;
	localparam logic [7:0]  IDENT_RESET = 8'h01;
	localparam logic [7:0]  LSTATE_RESET = 8'h60;
	localparam logic [15:0] DIV_HS_230K = 16'h8002;
	localparam logic [15:0] DIV_HS_460K = 16'h8001;
	localparam logic [2:0]  ID_LINE = 3'h3;
	localparam logic [2:0]  ID_RXD  = 3'h2;
	localparam logic [2:0]  ID_TX_HOLDING_EMPTY = 3'h1;
	localparam logic [2:0]  ID_MDM  = 3'h0;
	localparam int EV_RXD  = 0;
	localparam int EV_TX_HOLDING_EMPTY = 1;
	localparam int EV_LINE = 2;
	localparam int EV_MDM  = 3;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} host_req_t;
	typedef struct packed {
		logic       stick;
		logic       even;
		logic       parity;
		logic       stop2;
		logic [1:0] wlen;
	} frame_fmt_t;
endpackage

// ---- hdl/uart_serial.sv ----
// holds the serial shifter: transmit and receive of one character
// assumes a one-cycle 16x baud enable and a synchronised rx input
`timescale 1ns/1ns
module uart_serial (
	input  wire logic                 ref_clk,   // clock
	input  wire logic                 rst_n,     // sync reset
	input  wire logic                 tick16,    // 16x baud enable
	input  wire uart_pkg::frame_fmt_t fmt,       // line format
	input  wire logic                 brk,       // force break
	input  wire logic                 tx_load,   // start a character
	input  wire logic [7:0]           tx_byte,   // character to send
	output logic                      tx_busy,   // shifter holds data
	output logic                      txd,       // serial out
	input  wire logic                 rxd_s,     // synced serial in
	output logic                      rx_done,   // character received
	output logic [7:0]                rx_byte,   // received character
	output logic                      rx_perr,   // parity error, never set
	output logic                      rx_ferr    // framing error
);
	logic [11:0] tsh_q;
	logic [3:0]  tph_q, rph_q;
	logic [3:0]  tcnt_q, rcnt_q;
	logic [3:0]  nbits;
	logic        par_tx;
	logic        rbusy_q;
	logic [10:0] rsh_q;
	logic        txo_q;
	// unused upper data bits of short words
	wire  [7:0]  msk = 8'he0 << fmt.wlen;
	assign nbits  = 4'h6 + {2'h0, fmt.wlen} + {3'h0, fmt.parity} + {3'h0, fmt.stop2};
	assign par_tx = fmt.stick ? ~fmt.even : (^(tx_byte & ~msk)) ^ ~fmt.even;
	// start, data lsb first, parity, stop
	// bit 0 first
	// unused data bits read as ones, so they fall into the stop time
	wire [11:0] ppos   = 12'h001 << (4'h5 + {2'h0, fmt.wlen});
	wire [11:0] tframe = ({4'hf, tx_byte | msk} & ~(fmt.parity ? ppos : 12'h000))
		| ((fmt.parity && par_tx) ? ppos : 12'h000);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tsh_q <= 12'hfff; tph_q <= 4'h0; tcnt_q <= 4'h0; tx_busy <= 1'b0; txo_q <= 1'b1;
		end else if (tx_load && !tx_busy) begin
			tsh_q <= {tframe[10:0], 1'b0}; tph_q <= 4'h0; tcnt_q <= nbits + 4'h1; tx_busy <= 1'b1;
		end else if (tick16 && tx_busy) begin
			tph_q <= tph_q + 4'h1;
			if (tph_q == 4'hf) begin
				tsh_q <= {1'b1, tsh_q[11:1]};
				tcnt_q <= tcnt_q - 4'h1;
				if (tcnt_q == 4'h1) tx_busy <= 1'b0;
			end
			txo_q <= tsh_q[0];
		end else if (!tx_busy) begin
			txo_q <= 1'b1;
		end
	end
	assign txd = txo_q & ~brk;
	// taken before the stop sample lands, so parity shifts the data window
	wire [7:0] rraw = fmt.parity ? rsh_q[9:2] : rsh_q[10:3];
	wire [7:0] rdat = rraw >> (3'h3 - {1'b0, fmt.wlen});
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rbusy_q <= 1'b0; rph_q <= 4'h0; rcnt_q <= 4'h0; rsh_q <= 11'h000;
			rx_done <= 1'b0; rx_byte <= 8'h00; rx_perr <= 1'b0; rx_ferr <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick16) begin
				if (!rbusy_q) begin
					if (!rxd_s) begin
						rbusy_q <= 1'b1;
						rph_q <= 4'h1;
						// start, data, parity and the first stop only
						rcnt_q <= 4'h7 + {2'h0, fmt.wlen} + {3'h0, fmt.parity};
					end
				end else begin
					rph_q <= rph_q + 4'h1;
					if (rph_q == 4'h7) begin
						rsh_q <= {rxd_s, rsh_q[10:1]};
						rcnt_q <= rcnt_q - 4'h1;
						if (rcnt_q == 4'h1) begin
							rbusy_q <= 1'b0;
							rx_done <= 1'b1;
							rx_byte <= rdat & ~msk;
							rx_ferr <= ~rxd_s;
							rx_perr <= 1'b0;
						end
					end
				end
			end
		end
	end
endmodule

// ---- hdl/uart_regs.sv ----
// holds the host register file of one serial channel
// assumes a synchronous byte-wide register port from the host
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module uart_regs (
	input  wire logic       ref_clk,  // 20 MHz clock
	input  wire logic       rst_n,    // sync reset
	input  wire logic [7:0] addr,     // register offset
	input  wire logic [7:0] wdata,    // write data
	input  wire logic       wr,       // write strobe
	input  wire logic       rd,       // read strobe
	output logic [7:0]      rdata,    // read data next cycle
	output logic            txd,      // serial out
	input  wire logic       rxd,      // serial in
	input  wire logic [3:0] mdm_in,   // cts dsr ri dcd
	output logic            dtr_n,    // terminal ready
	output logic            rts_n,    // request to send
	output logic            irq       // interrupt level
);
	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0]  ien_q, lfmt_q, mctl_q, scr_q, fcr_q, sh1_q, sh2_q, cfg_q;
	logic [7:0]  dll_q, dlm_q, thr_q, rbr_q;
	logic        thr_full_q, dr_q, oe_q, pe_q, fe_q, rdata_sel;
	logic [3:0]  ev_q, evn_q, dmdm_q;
	logic [3:0]  mdm_s1_q, mdm_s2_q, mdm_old_q;
	logic        rx_s1_q, rx_s2_q;
	logic [7:0]  rdata_d;
	logic [15:0] bcnt_q;
	logic        tick16, tx_busy, rx_done, rx_perr, rx_ferr;
	logic [7:0]  rx_byte;
	wire         bank   = lfmt_q[uart_pkg::LF_BANK];
	wire         fifo_on = fcr_q[uart_pkg::FC_ENABLE];
	wire         legacy = cfg_q[uart_pkg::CFG_LEGACY];
	wire         is_lo  = addr[7:3] == 5'h00;
	wire         w_thr  = wr && is_lo && addr[2:0] == uart_pkg::OFS_DATA && !bank;
	wire         w_dll  = wr && is_lo && addr[2:0] == uart_pkg::OFS_DATA && bank;
	wire         w_ien  = wr && is_lo && addr[2:0] == uart_pkg::OFS_IEN && !bank;
	wire         w_dlm  = wr && is_lo && addr[2:0] == uart_pkg::OFS_IEN && bank;
	wire         w_fcr  = wr && is_lo && addr[2:0] == uart_pkg::OFS_IDENT;
	wire         r_rbr  = rd && is_lo && addr[2:0] == uart_pkg::OFS_DATA && !bank;
	wire         r_lsr  = rd && is_lo && addr[2:0] == uart_pkg::OFS_LSTATE;
	wire         r_iir  = rd && is_lo && addr[2:0] == uart_pkg::OFS_IDENT;
	wire         r_msr  = rd && is_lo && addr[2:0] == uart_pkg::OFS_MSTATE;
	wire [15:0]  divisor = {dlm_q, dll_q};
	// high-speed codes 8002 and 8001 both map to a divide of 1
	wire         hs = cfg_q[uart_pkg::CFG_HSPEED];
	wire         hs_tick = hs && (divisor == uart_pkg::DIV_HS_230K || divisor == uart_pkg::DIV_HS_460K);
	wire [15:0]  div_eff = (divisor == 16'h0000) ? 16'h0001 : (hs_tick ? 16'h0001 : divisor);
	// ****************************************************************
	// baud divider and serial core
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n || bcnt_q + 16'h0001 >= div_eff) bcnt_q <= 16'h0000;
		else bcnt_q <= bcnt_q + 16'h0001;
	end
	assign tick16 = bcnt_q + 16'h0001 >= div_eff;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin rx_s1_q <= 1'b1; rx_s2_q <= 1'b1; mdm_s1_q <= 4'h0; mdm_s2_q <= 4'h0; end
		else begin rx_s1_q <= rxd; rx_s2_q <= rx_s1_q; mdm_s1_q <= mdm_in; mdm_s2_q <= mdm_s1_q; end
	end
	uart_serial u_ser (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick16  (tick16),
		.fmt     (lfmt_q[5:0]),
		.brk     (lfmt_q[uart_pkg::LF_BREAK]),
		.tx_load (thr_full_q),
		.tx_byte (thr_q),
		.tx_busy (tx_busy),
		.txd     (txd),
		.rxd_s   (mctl_q[4] ? txd : rx_s2_q),
		.rx_done (rx_done),
		.rx_byte (rx_byte),
		.rx_perr (rx_perr),
		.rx_ferr (rx_ferr)
	);
	// ****************************************************************
	// register writes
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ien_q <= 8'h00; lfmt_q <= 8'h00; mctl_q <= 8'h00; scr_q <= 8'h00; fcr_q <= 8'h00;
			sh1_q <= 8'h00; sh2_q <= 8'h00; cfg_q <= 8'h00; dll_q <= 8'h00; dlm_q <= 8'h00;
			thr_q <= 8'h00;
		end else if (wr) begin
			if (w_dll) dll_q <= wdata;
			if (w_dlm) dlm_q <= wdata;
			if (w_ien) ien_q <= {4'h0, wdata[3:0]};
			if (w_thr) thr_q <= wdata;
			if (w_fcr) fcr_q <= {wdata[7:6], 5'h00, wdata[0]};
			// shadow copy of the raw write
			if (w_fcr && !cfg_q[uart_pkg::CFG_CHAN2]) sh1_q <= wdata;
			if (w_fcr && cfg_q[uart_pkg::CFG_CHAN2]) sh2_q <= wdata;
			if (is_lo && addr[2:0] == uart_pkg::OFS_LFMT) lfmt_q <= wdata;
			if (is_lo && addr[2:0] == uart_pkg::OFS_MCTL) mctl_q <= {3'h0, wdata[4:0]};
			if (is_lo && addr[2:0] == uart_pkg::OFS_SCR && !legacy) scr_q <= wdata;
			if (addr == uart_pkg::OFS_CONFIG) cfg_q <= {5'h00, wdata[2:0]};
		end
	end
	// ****************************************************************
	// line and event state
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			thr_full_q <= 1'b0; dr_q <= 1'b0; oe_q <= 1'b0; pe_q <= 1'b0; fe_q <= 1'b0;
			rbr_q <= 8'h00; dmdm_q <= 4'h0; mdm_old_q <= 4'h0;
		end else begin
			if (w_thr) thr_full_q <= 1'b1;
			else if (!tx_busy) thr_full_q <= 1'b0;
			if (rx_done) begin
				rbr_q <= rx_byte; dr_q <= 1'b1; oe_q <= dr_q; pe_q <= rx_perr; fe_q <= rx_ferr;
			end else begin
				if (r_rbr) dr_q <= 1'b0;
				if (r_lsr) begin oe_q <= 1'b0; pe_q <= 1'b0; fe_q <= 1'b0; end
			end
			// receive clear drops the held character
			if (w_fcr && wdata[uart_pkg::FC_RXCLR] && !rx_done) dr_q <= 1'b0;
			mdm_old_q <= mdm_s2_q;
			dmdm_q <= (r_msr ? 4'h0 : dmdm_q) | (mdm_s2_q ^ mdm_old_q);
		end
	end
	assign evn_q = {|dmdm_q, oe_q | pe_q | fe_q, ~thr_full_q, dr_q};
	logic [3:0] ev_q_prev;
	// sticky events: a new event beats a same-cycle clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ev_q <= 4'h0;
		else ev_q <= (ev_q & ~((wr && addr == uart_pkg::OFS_EV_CLEAR) ? wdata[3:0] : 4'h0)) | (evn_q & ~ev_q_prev);
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ev_q_prev <= 4'h0;
		else ev_q_prev <= evn_q;
	end
	logic [3:0] ev_en_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ev_en_q <= 4'h0;
		else if (wr && addr == uart_pkg::OFS_EV_ENABLE) ev_en_q <= wdata[3:0];
	end
	assign irq = |(ev_q & ev_en_q);
	// ****************************************************************
	// identification and read mux
	// ****************************************************************
	wire [3:0]  pend = evn_q & ien_q[3:0];
	// priority line > rx > tx_holding_empty > modem
	wire [2:0]  code = pend[uart_pkg::EV_LINE] ? uart_pkg::ID_LINE : pend[uart_pkg::EV_RXD] ? uart_pkg::ID_RXD
		: pend[uart_pkg::EV_TX_HOLDING_EMPTY] ? uart_pkg::ID_TX_HOLDING_EMPTY : uart_pkg::ID_MDM;
	// fifo bits only in fifo mode
	wire [7:0]  iir_v = {fifo_on, fifo_on, 2'h0, code & {3{|pend}}, ~|pend};
	wire [7:0]  iir_w = {iir_v[7:4], 1'b0, iir_v[2:0]};
	// legacy forces empty on idle shifter
	wire        transmitter_empty = legacy ? !tx_busy : (!tx_busy && !thr_full_q);
	wire [7:0]  lsr_v = {fifo_on & (pe_q | fe_q), transmitter_empty, ~thr_full_q, 1'b0, fe_q, pe_q, oe_q, dr_q};
	wire [7:0]  msr_v = {mdm_s2_q, dmdm_q};
	assign rdata_d = !is_lo ? ((addr == uart_pkg::OFS_FCR_SHADOW1) ? sh1_q : (addr == uart_pkg::OFS_FCR_SHADOW2) ? sh2_q
		: (addr == uart_pkg::OFS_EV_STATUS) ? {4'h0, ev_q} : (addr == uart_pkg::OFS_EV_ENABLE) ? {4'h0, ev_en_q}
		: (addr == uart_pkg::OFS_CONFIG) ? cfg_q : 8'h00)
		: (addr[2:0] == uart_pkg::OFS_DATA) ? (bank ? dll_q : rbr_q)
		: (addr[2:0] == uart_pkg::OFS_IEN) ? (bank ? dlm_q : ien_q)
		: (addr[2:0] == uart_pkg::OFS_IDENT) ? iir_w
		: (addr[2:0] == uart_pkg::OFS_LFMT) ? lfmt_q
		: (addr[2:0] == uart_pkg::OFS_MCTL) ? mctl_q
		: (addr[2:0] == uart_pkg::OFS_LSTATE) ? lsr_v
		: (addr[2:0] == uart_pkg::OFS_MSTATE) ? msr_v
		: (legacy ? 8'h00 : scr_q);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) rdata <= 8'h00;
		else if (rd) rdata <= rdata_d;
		else rdata <= 8'h00;
	end
	// pins from bits 0 and 1 only
	assign dtr_n = ~mctl_q[0];
	assign rts_n = ~mctl_q[1];
	assign rdata_sel = r_iir;
	// ****************************************************************
	// checks
	// ****************************************************************
	a_ident_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pend == 4'h0) |-> iir_w[0]) else $error("ident idle bit wrong");
	a_fifo_bits_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!fifo_on |-> (iir_w[7:6] == 2'h0 && iir_w[3] == 1'b0 && lsr_v[7] == 1'b0)) else $error("fifo bits set");
	a_shadow_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(w_fcr && !cfg_q[2]) |=> sh1_q == $past(wdata)) else $error("shadow not copied");
	a_legacy_transmitter_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(legacy && !tx_busy) |-> lsr_v[6]) else $error("legacy empty missing");
	a_dma_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fcr_q[3] == 1'b0) else $error("dma bit stored");
	a_scratch_hidden: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd && addr == 8'h07 && legacy) |=> rdata == 8'h00) else $error("scratch visible");
	a_bank_divisor: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(w_dll) |=> dll_q == $past(wdata) && rbr_q == $past(rbr_q)) else $error("divisor bank wrong");
	a_line_reset: assert property (@(posedge ref_clk)
		!rst_n |=> lsr_v == 8'h60) else $error("line state reset wrong");
endmodule

// ---- verif/serial_peer.sv ----
// holds a remote serial device model facing the channel's line pins
// assumes one bit lasts BIT_CYC ref_clk cycles and 8 data bits, no parity
`timescale 1ns/1ns
module serial_peer #(
	parameter int BIT_CYC = 16
) (
	input  wire logic       ref_clk,   // clock
	input  wire logic       txd,       // line from the channel
	output logic            rxd,       // line to the channel
	input  wire logic       send,      // start one frame
	input  wire logic [7:0] send_byte, // character to send
	output logic [7:0]      seen_byte, // last character caught
	output int              seen_cnt   // characters caught
);
	initial begin
		rxd = 1'b1;
		seen_cnt = 0;
		seen_byte = 8'h00;
	end
	always @(posedge ref_clk) begin
		if (send) begin
			rxd <= 1'b0;
			repeat (BIT_CYC) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				rxd <= send_byte[i];
				repeat (BIT_CYC) @(posedge ref_clk);
			end
			rxd <= 1'b1;
		end
	end
	// first bit caught is bit 0
	always @(negedge txd) begin
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			seen_byte[i] = txd;
		end
		seen_cnt++;
	end
endmodule

// ---- verif/uart_channel_register_map_tb_top.sv ----
// holds the self-checking bench of the channel register file
// assumes the 16x enable fires every divisor cycles, so divisor 1 gives 16-cycle bits
`timescale 1ns/1ns
module uart_channel_register_map_tb_top;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       txd, rxd, dtr_n, rts_n, irq;
	logic [3:0] mdm_in = 4'h0;
	logic       send = 1'b0;
	logic [7:0] send_byte = 8'h00;
	logic [7:0] seen_byte;
	int         seen_cnt, fails = 0, compares = 0, cyc = 0;
	logic [7:0] v;

	always #25 ref_clk = ~ref_clk;

	uart_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .txd(txd), .rxd(rxd), .mdm_in(mdm_in), .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq));
	serial_peer #(.BIT_CYC(16)) peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .send(send),
		.send_byte(send_byte), .seen_byte(seen_byte), .seen_cnt(seen_cnt));

	// ************************
	// bus and check tasks
	// ************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// read data is caught in the one cycle after the strobe is taken
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a, v);
		check(what, v, exp);
	endtask

	// ************************
	// scenarios
	// ************************
	task automatic t_reset;
		rd_chk("ident", 8'h02, 8'h01);
		rd_chk("line state", 8'h05, 8'h60);
		check("txd idle", {7'h00, txd}, 8'h01);
		$display("test reset done");
	endtask
	task automatic t_bank;
		wr_reg(8'h03, 8'h83);
		wr_reg(8'h00, 8'h01);
		wr_reg(8'h01, 8'h00);
		rd_chk("div low", 8'h00, 8'h01);
		rd_chk("div high", 8'h01, 8'h00);
		wr_reg(8'h03, 8'h03);
		wr_reg(8'h01, 8'h05);
		rd_chk("irq enable", 8'h01, 8'h05);
		wr_reg(8'h03, 8'h83);
		rd_chk("div high kept", 8'h01, 8'h00);
		wr_reg(8'h03, 8'h03);
		wr_reg(8'h01, 8'h00);
		$display("test bank done");
	endtask
	task automatic t_fifo;
		wr_reg(8'h02, 8'h08);
		rd_chk("ident dma only", 8'h02, 8'h01);
		rd_chk("line state nofifo", 8'h05, 8'h60);
		wr_reg(8'h02, 8'hc9);
		rd_chk("shadow one", 8'h20, 8'hc9);
		wr_reg(8'h33, 8'h04);
		wr_reg(8'h02, 8'h41);
		rd_chk("shadow two", 8'h21, 8'h41);
		rd_chk("shadow one kept", 8'h20, 8'hc9);
		wr_reg(8'h33, 8'h00);
		wr_reg(8'h02, 8'h00);
		rd_reg(8'h02, v);
		check("ident fifo bits", v & 8'hc8, 8'h00);
		check("ident not fcr", v, 8'h01);
		$display("test fifo done");
	endtask
	task automatic t_modem;
		wr_reg(8'h04, 8'h0c);
		rd_chk("modem ctrl aux", 8'h04, 8'h0c);
		check("pins aux", {6'h00, dtr_n, rts_n}, 8'h03);
		wr_reg(8'h04, 8'h03);
		#1 check("pins on", {6'h00, dtr_n, rts_n}, 8'h00);
		wr_reg(8'h04, 8'h00);
		wr_reg(8'h10, 8'hff);
		rd_chk("unmapped", 8'h10, 8'h00);
		$display("test modem done");
	endtask
	task automatic t_serial;
		int n;
		wr_reg(8'h01, 8'h01);
		wr_reg(8'h32, 8'h01);
		@(posedge ref_clk);
		send_byte <= 8'h3c;
		send <= 1'b1;
		@(posedge ref_clk);
		send <= 1'b0;
		for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge ref_clk);
		check("irq raised", {7'h00, irq}, 8'h01);
		rd_chk("ident rx", 8'h02, {4'h0, uart_pkg::ID_RXD, 1'b0});
		n = seen_cnt;
		wr_reg(8'h00, 8'ha5);
		rd_chk("rx buffer", 8'h00, 8'h3c);
		wr_reg(8'h31, 8'h0f);
		#1 check("irq cleared", {7'h00, irq}, 8'h00);
		repeat (250) @(posedge ref_clk);
		check("tx count", 8'(seen_cnt - n), 8'h01);
		check("tx byte", seen_byte, 8'ha5);
		rd_reg(8'h05, v);
		check("tx empty", v & 8'h60, 8'h60);
		wr_reg(8'h32, 8'h00);
		wr_reg(8'h01, 8'h00);
		$display("test serial done");
	endtask
	task automatic t_format;
		wr_reg(8'h03, 8'h7b);
		rd_chk("line format", 8'h03, 8'h7b);
		wr_reg(8'h03, 8'h43);
		repeat (3) @(posedge ref_clk);
		check("break low", {7'h00, txd}, 8'h00);
		wr_reg(8'h03, 8'h03);
		repeat (200) @(posedge ref_clk);
		check("break off", {7'h00, txd}, 8'h01);
		$display("test format done");
	endtask
	task automatic t_scratch;
		wr_reg(8'h07, 8'ha5);
		rd_chk("scratch", 8'h07, 8'ha5);
		wr_reg(8'h33, 8'h01);
		rd_chk("scratch legacy", 8'h07, 8'h00);
		wr_reg(8'h07, 8'h5a);
		rd_reg(8'h05, v);
		check("legacy tx empty", v & 8'h40, 8'h40);
		wr_reg(8'h33, 8'h00);
		rd_chk("scratch kept", 8'h07, 8'ha5);
		$display("test scratch done");
	endtask

	// ************************
	// run control
	// ************************
	task automatic stop_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// all scenarios fit well inside this ceiling
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_bank();
		t_fifo();
		t_modem();
		t_serial();
		t_format();
		t_scratch();
		stop_test();
	end
endmodule
